// ==== gpab_map.svh ====
`ifndef GPAB_MAP_SVH
`define GPAB_MAP_SVH

// Register byte offsets, one aligned 32-bit word each
`define GPAB_TIMER_PORT_DATA_OFS          8'h00
`define GPAB_TIMER_PORT_DIRECTION_OFS     8'h04
`define GPAB_HIGH_ADDR_PORT_DATA_OFS      8'h08
`define GPAB_HIGH_ADDR_PORT_DIRECTION_OFS 8'h0c
`define GPAB_PULLUP_ASSIGNMENT_OFS        8'h10
`define GPAB_MODE_STATUS_OFS              8'h14
`define GPAB_TIMER_PORT_DRIVE_OFS         8'h18
`define GPAB_HIGH_ADDR_PORT_DRIVE_OFS     8'h1c

// Field positions
`define GPAB_PULLUP_HIGH_ADDR_BIT         0
`define GPAB_STATUS_MODE_LSB              0
`define GPAB_STATUS_MODE_MSB              1
`define GPAB_STATUS_BUS_OWNED_BIT         2

// Reset values
`define GPAB_PORT_DATA_RST                8'h00
`define GPAB_PORT_DIRECTION_RST           8'h00
`define GPAB_PULLUP_ASSIGNMENT_RST        8'h00
`define GPAB_PIN_DRIVE_RST                1'b0

// Strap codes, {mode_b, mode_a}
`define GPAB_STRAP_BOOTSTRAP              2'h0
`define GPAB_STRAP_TEST                   2'h1
`define GPAB_STRAP_SINGLE_CHIP            2'h2
`define GPAB_STRAP_EXPANDED               2'h3

// Bus answer latency in clock cycles after the request is seen
`define GPAB_ACK_LATENCY                  1

`endif

// ==== gpab_pkg.sv ====
package gpab_pkg;

  typedef enum logic [1:0] {
    GPAB_MODE_BOOTSTRAP,
    GPAB_MODE_TEST,
    GPAB_MODE_SINGLE_CHIP,
    GPAB_MODE_EXPANDED
  } gpab_mode_t;

  typedef logic [7:0] gpab_byte_t;

endpackage : gpab_pkg

// ==== gpab_pin_drv.sv ====
`timescale 1ns/100ps
`include "gpab_map.svh"

module gpab_pin_drv (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] latch_i,
  input  wire logic [7:0] dir_i,
  input  wire logic       gpio_ok_i,
  input  wire logic [7:0] alt_en_i,
  input  wire logic [7:0] alt_val_i,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe_o
);

  logic [7:0] pin_d;
  logic [7:0] pin_oe_d;

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      // Alternate function owns the pin; latch only drives in GPIO output mode
      assign pin_d[b]    = alt_en_i[b] ? alt_val_i[b] : latch_i[b];
      assign pin_oe_d[b] = alt_en_i[b] | (dir_i[b] & gpio_ok_i);
    end
  endgenerate

  // One register process for the whole port keeps a single driver per output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o    <= {8{`GPAB_PIN_DRIVE_RST}};
      pin_oe_o <= {8{`GPAB_PIN_DRIVE_RST}};
    end else begin
      pin_o    <= pin_d;
      pin_oe_o <= pin_oe_d;
    end
  end

endmodule : gpab_pin_drv

// ==== gpab_ports.sv ====
`timescale 1ns/100ps
`include "gpab_map.svh"

// Overview of operation
// RQ1: Reading timer port data returns live pin levels regardless of direction.
// RQ2: Timer port writes go to latches; pin shows latch only when output.
// RQ3: Pins owned by timer output compare ignore timer port data writes.
// RQ4: After reset all timer port pins are undriven inputs.
// RQ5: With timer function off, the direction bit selects input or output.
// RQ6: High address port is GPIO in single chip, address A15..A8 expanded.
// RQ7: High address port drives latch only if output and single chip/bootstrap.
// RQ8: High address port reads return pin levels; writes are latched.
// RQ9: Upper four high address pins may drive LCD segments in any mode.
// RQ10: High address port pull-ups are switched by the pullup assignment register.
// RQ11: Pins that are inputs at reset are high impedance.
// RQ12: Data registers reset to the functional state, not to pin levels.
// RQ13: Bus ports give GPIO only in single chip/bootstrap, bus in expanded/test.
// RQ14: Direction bit one means output, zero input; all clear on reset.

module gpab_ports (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Mode straps, caught while reset is held
  input  wire logic        mode_a_i,
  input  wire logic        mode_b_i,
  output logic      [1:0]  mode_o,
  // Timer port pins
  input  wire logic [7:0]  timer_port_pin_i,
  output logic      [7:0]  timer_port_pin_o,
  output logic      [7:0]  timer_port_pin_oe_o,
  // Timer connections
  input  wire logic [7:0]  timer_oc_en_i,
  input  wire logic [7:0]  timer_oc_val_i,
  output logic      [7:0]  timer_capture_o,
  // High address port pins
  input  wire logic [7:0]  high_addr_port_pin_i,
  output logic      [7:0]  high_addr_port_pin_o,
  output logic      [7:0]  high_addr_port_pin_oe_o,
  output logic      [7:0]  high_addr_port_pullup_o,
  // External bus high address and LCD segment drive
  input  wire logic [7:0]  ext_addr_hi_i,
  input  wire logic [3:0]  lcd_seg_en_i,
  input  wire logic [3:0]  lcd_seg_i
);

  gpab_pkg::gpab_mode_t mode_q;
  logic [7:0]           timer_port_data_q;
  logic [7:0]           timer_port_direction_q;
  logic [7:0]           high_addr_port_data_q;
  logic [7:0]           high_addr_port_direction_q;
  logic [7:0]           pullup_assignment_q;
  logic [7:0]           timer_capture_q;
  logic                 ack_q;
  logic [31:0]          dat_q;
  logic [31:0]          dat_d;
  logic                 req;
  logic                 wr_en;
  logic                 gpio_mode;
  logic                 bus_owned;
  logic [7:0]           high_addr_alt_en;
  logic [7:0]           high_addr_alt_val;
  logic [7:0]           pullup_en;

  // Bus request and write commit
  assign req   = cyc_i & stb_i;
  assign wr_en = req & we_i & ack_q & sel_i[0];

  // Operating mode
  assign gpio_mode = (mode_q == gpab_pkg::GPAB_MODE_SINGLE_CHIP) |
                     (mode_q == gpab_pkg::GPAB_MODE_BOOTSTRAP);  // RQ13
  assign bus_owned = ~gpio_mode;  // RQ13
  assign mode_o    = mode_q;

  function automatic gpab_pkg::gpab_mode_t strap_decode(input logic [1:0] s);
    gpab_pkg::gpab_mode_t m;
    m = gpab_pkg::GPAB_MODE_SINGLE_CHIP;
    case (s)
      `GPAB_STRAP_BOOTSTRAP:   m = gpab_pkg::GPAB_MODE_BOOTSTRAP;
      `GPAB_STRAP_TEST:        m = gpab_pkg::GPAB_MODE_TEST;
      `GPAB_STRAP_SINGLE_CHIP: m = gpab_pkg::GPAB_MODE_SINGLE_CHIP;
      `GPAB_STRAP_EXPANDED:    m = gpab_pkg::GPAB_MODE_EXPANDED;
      default:                 m = gpab_pkg::GPAB_MODE_SINGLE_CHIP;
    endcase
    return m;
  endfunction : strap_decode

  // Straps follow the pins while reset is held and freeze at release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= strap_decode({mode_b_i, mode_a_i});
    end
  end

  // Wishbone acknowledge: one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  assign ack_o = ack_q;

  // Timer port data latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_port_data_q <= `GPAB_PORT_DATA_RST;  // RQ12
    end else if (wr_en && adr_i == `GPAB_TIMER_PORT_DATA_OFS) begin
      timer_port_data_q <= dat_i[7:0];  // RQ2
    end
  end

  // Timer port direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_port_direction_q <= `GPAB_PORT_DIRECTION_RST;  // RQ14
    end else if (wr_en && adr_i == `GPAB_TIMER_PORT_DIRECTION_OFS) begin
      timer_port_direction_q <= dat_i[7:0];
    end
  end

  // High address port data latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_addr_port_data_q <= `GPAB_PORT_DATA_RST;  // RQ12
    end else if (wr_en && adr_i == `GPAB_HIGH_ADDR_PORT_DATA_OFS) begin
      high_addr_port_data_q <= dat_i[7:0];  // RQ8
    end
  end

  // High address port direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_addr_port_direction_q <= `GPAB_PORT_DIRECTION_RST;  // RQ14
    end else if (wr_en && adr_i == `GPAB_HIGH_ADDR_PORT_DIRECTION_OFS) begin
      high_addr_port_direction_q <= dat_i[7:0];
    end
  end

  // Pull-up assignment, only the high address port bit is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pullup_assignment_q <= `GPAB_PULLUP_ASSIGNMENT_RST;
    end else if (wr_en && adr_i == `GPAB_PULLUP_ASSIGNMENT_OFS) begin
      pullup_assignment_q <= {7'h00, dat_i[`GPAB_PULLUP_HIGH_ADDR_BIT]};  // RQ10
    end
  end

  // Timer port: output compare owns a pin, otherwise direction decides
  gpab_pin_drv u_timer_port (
    .clk_i     (clk_i),
    .rst_i     (rst_i),  // RQ4
    .latch_i   (timer_port_data_q),  // RQ2
    .dir_i     (timer_port_direction_q),  // RQ5
    .gpio_ok_i (1'b1),
    .alt_en_i  (timer_oc_en_i),  // RQ3
    .alt_val_i (timer_oc_val_i),
    .pin_o     (timer_port_pin_o),
    .pin_oe_o  (timer_port_pin_oe_o)
  );

  // Input capture sees the live pin level whatever the direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_capture_q <= 8'h00;
    end else begin
      timer_capture_q <= timer_port_pin_i;
    end
  end

  assign timer_capture_o = timer_capture_q;

  // High address port: LCD segments on the top nibble win over bus and GPIO
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_high_addr
      if (i >= 4) begin : g_lcd
        assign high_addr_alt_en[i]  = lcd_seg_en_i[i-4] | bus_owned;  // RQ9
        assign high_addr_alt_val[i] = lcd_seg_en_i[i-4] ? lcd_seg_i[i-4]
                                                        : ext_addr_hi_i[i];  // RQ9
      end else begin : g_addr
        assign high_addr_alt_en[i]  = bus_owned;  // RQ6
        assign high_addr_alt_val[i] = ext_addr_hi_i[i];  // RQ6
      end
    end
  endgenerate

  gpab_pin_drv u_high_addr_port (
    .clk_i     (clk_i),
    .rst_i     (rst_i),  // RQ11
    .latch_i   (high_addr_port_data_q),
    .dir_i     (high_addr_port_direction_q),
    .gpio_ok_i (gpio_mode),  // RQ7
    .alt_en_i  (high_addr_alt_en),
    .alt_val_i (high_addr_alt_val),
    .pin_o     (high_addr_port_pin_o),
    .pin_oe_o  (high_addr_port_pin_oe_o)
  );

  // Pull-ups act only on pins that are not being driven
  assign pullup_en = {8{pullup_assignment_q[`GPAB_PULLUP_HIGH_ADDR_BIT]}};
  assign high_addr_port_pullup_o = pullup_en & ~high_addr_port_pin_oe_o;  // RQ10

  // Read data, unmapped offsets read zero
  always_comb begin
    dat_d = 32'h0000_0000;
    case (adr_i)
      `GPAB_TIMER_PORT_DATA_OFS:          dat_d[7:0] = timer_port_pin_i;  // RQ1
      `GPAB_TIMER_PORT_DIRECTION_OFS:     dat_d[7:0] = timer_port_direction_q;
      `GPAB_HIGH_ADDR_PORT_DATA_OFS:      dat_d[7:0] = high_addr_port_pin_i;  // RQ8
      `GPAB_HIGH_ADDR_PORT_DIRECTION_OFS: dat_d[7:0] = high_addr_port_direction_q;
      `GPAB_PULLUP_ASSIGNMENT_OFS:        dat_d[7:0] = pullup_assignment_q;
      `GPAB_MODE_STATUS_OFS: begin
        dat_d[`GPAB_STATUS_MODE_MSB:`GPAB_STATUS_MODE_LSB] = mode_q;
        dat_d[`GPAB_STATUS_BUS_OWNED_BIT]                  = bus_owned;
      end
      `GPAB_TIMER_PORT_DRIVE_OFS:         dat_d[7:0] = timer_port_pin_oe_o;
      `GPAB_HIGH_ADDR_PORT_DRIVE_OFS:     dat_d[7:0] = high_addr_port_pin_oe_o;
      default:                            dat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      dat_q <= dat_d;
    end
  end

  assign dat_o = dat_q;

endmodule : gpab_ports

// ==== gpab_ports_sva.sv ====
`timescale 1ns/100ps
module gpab_ports_sva (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic [1:0] mode_o,
  input wire logic [7:0] timer_oc_en_i,
  input wire logic [7:0] timer_oc_val_i,
  input wire logic [7:0] timer_port_pin_o,
  input wire logic [7:0] timer_port_pin_oe_o,
  input wire logic [7:0] high_addr_port_pin_o,
  input wire logic [7:0] high_addr_port_pin_oe_o,
  input wire logic [7:0] high_addr_port_pullup_o,
  input wire logic [7:0] ext_addr_hi_i,
  input wire logic [3:0] lcd_seg_en_i,
  input wire logic [3:0] lcd_seg_i
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_oc_owns_pin: assert property (!$past(rst_i) |->
    ((timer_port_pin_o ^ $past(timer_oc_val_i)) & $past(timer_oc_en_i)) == 8'h00
    && (timer_port_pin_oe_o & $past(timer_oc_en_i)) == $past(timer_oc_en_i))
    else $error("compare pin not following timer");
  a_reset_pins_off: assert property ($fell(rst_i) |->
    timer_port_pin_oe_o == 8'h00 && high_addr_port_pin_oe_o == 8'h00)
    else $error("pin driven after reset");
  a_bus_addr_out: assert property (mode_o[0] && !$past(rst_i) |->
    high_addr_port_pin_oe_o[3:0] == 4'hf
    && high_addr_port_pin_o[3:0] == $past(ext_addr_hi_i[3:0]))
    else $error("address not on high port");
  a_lcd_seg_out: assert property (!$past(rst_i) |->
    ((high_addr_port_pin_o[7:4] ^ $past(lcd_seg_i)) & $past(lcd_seg_en_i)) == 4'h0)
    else $error("segment drive wrong");
  a_pullup_release: assert property ((high_addr_port_pullup_o & high_addr_port_pin_oe_o) == 8'h00)
    else $error("pull-up on driven pin");
  a_mode_frozen: assert property (!$past(rst_i) |-> $stable(mode_o))
    else $error("mode changed outside reset");
  c_ack: cover property (ack_o);
  c_oc: cover property (|timer_oc_en_i);
  c_bus: cover property (mode_o[0]);
  c_lcd: cover property (|lcd_seg_en_i);
endmodule : gpab_ports_sva

bind gpab_ports gpab_ports_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .mode_o(mode_o), .timer_oc_en_i(timer_oc_en_i),
  .timer_oc_val_i(timer_oc_val_i), .timer_port_pin_o(timer_port_pin_o),
  .timer_port_pin_oe_o(timer_port_pin_oe_o), .high_addr_port_pin_o(high_addr_port_pin_o),
  .high_addr_port_pin_oe_o(high_addr_port_pin_oe_o), .ext_addr_hi_i(ext_addr_hi_i),
  .high_addr_port_pullup_o(high_addr_port_pullup_o), .lcd_seg_en_i(lcd_seg_en_i),
  .lcd_seg_i(lcd_seg_i));

// ==== gpab_pin_model.sv ====
`timescale 1ns/100ps
module gpab_pin_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pu_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] pin_i_o
);
  // Undriven pins without pull-up wander every cycle
  logic [7:0] float_q = 8'h55;
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  assign pin_i_o = (oe_i & pin_o_i) | (~oe_i & ext_en_i & ext_val_i)
                 | (~oe_i & ~ext_en_i & (pu_i | float_q));
endmodule : gpab_pin_model

// ==== tb_gpab_ports.sv ====
`timescale 1ns/100ps
`include "gpab_map.svh"
module tb_gpab_ports;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        mode_a_i = 1'b0, mode_b_i = 1'b1, ack_o;
  logic [7:0]  adr_i = 8'h00, oc_en = 8'h00, oc_val = 8'h00, ext_hi = 8'ha7, ext_v = 8'h5a;
  logic [7:0]  ext_en_a = 8'hff, ta_i, ta_o, ta_oe, hb_i, hb_o, hb_oe, hb_pu;
  logic [3:0]  sel_i = 4'hf, lcd_en = 4'h0, lcd_v = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [1:0]  mode_o;
  logic [7:0]  cap;
  int          num_errors = 0, checked = 0, cycles = 0;
  always #10 clk_i = ~clk_i;
  gpab_ports u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .mode_a_i(mode_a_i), .mode_b_i(mode_b_i), .mode_o(mode_o), .timer_port_pin_i(ta_i),
    .timer_port_pin_o(ta_o), .timer_port_pin_oe_o(ta_oe), .timer_oc_en_i(oc_en),
    .timer_oc_val_i(oc_val), .timer_capture_o(cap), .high_addr_port_pin_i(hb_i),
    .high_addr_port_pin_o(hb_o), .high_addr_port_pin_oe_o(hb_oe), .ext_addr_hi_i(ext_hi),
    .high_addr_port_pullup_o(hb_pu), .lcd_seg_en_i(lcd_en), .lcd_seg_i(lcd_v));
  gpab_pin_model u_pins_a (.clk_i(clk_i), .pin_o_i(ta_o), .oe_i(ta_oe), .pu_i(8'h00),
    .ext_en_i(ext_en_a), .ext_val_i(ext_v), .pin_i_o(ta_i));
  gpab_pin_model u_pins_b (.clk_i(clk_i), .pin_o_i(hb_o), .oe_i(hb_oe), .pu_i(hb_pu),
    .ext_en_i(8'h00), .ext_val_i(ext_v), .pin_i_o(hb_i));
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(what, exp, rd[7:0]);
  endtask : rdchk
  task automatic do_reset(input logic [1:0] m);
    rst_i <= 1'b1;
    mode_b_i <= m[1];
    mode_a_i <= m[0];
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset
  task automatic t_reset_state;
    rdchk("status", `GPAB_MODE_STATUS_OFS, 8'h02);
    rdchk("timer dir", `GPAB_TIMER_PORT_DIRECTION_OFS, 8'h00);
    rdchk("high dir", `GPAB_HIGH_ADDR_PORT_DIRECTION_OFS, 8'h00);
    rdchk("timer drive", `GPAB_TIMER_PORT_DRIVE_OFS, 8'h00);
    rdchk("high drive", `GPAB_HIGH_ADDR_PORT_DRIVE_OFS, 8'h00);
    rdchk("timer pins", `GPAB_TIMER_PORT_DATA_OFS, 8'h5a);
    chk("capture", 8'h5a, cap);
  endtask : t_reset_state
  task automatic t_timer_port;
    ext_en_a <= 8'hf0;
    wb(1'b1, `GPAB_TIMER_PORT_DIRECTION_OFS, 8'h0f);
    wb(1'b1, `GPAB_TIMER_PORT_DATA_OFS, 8'ha5);
    rdchk("timer mixed", `GPAB_TIMER_PORT_DATA_OFS, 8'h55);
    rdchk("timer drive", `GPAB_TIMER_PORT_DRIVE_OFS, 8'h0f);
    oc_en <= 8'h01;
    wb(1'b1, `GPAB_TIMER_PORT_DATA_OFS, 8'hff);
    rdchk("compare pin", `GPAB_TIMER_PORT_DATA_OFS, 8'h5e);
  endtask : t_timer_port
  task automatic t_pullup;
    wb(1'b1, `GPAB_PULLUP_ASSIGNMENT_OFS, 8'h01);
    rdchk("pulled pins", `GPAB_HIGH_ADDR_PORT_DATA_OFS, 8'hff);
  endtask : t_pullup
  task automatic t_modes;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      do_reset(m);
      wb(1'b1, `GPAB_HIGH_ADDR_PORT_DIRECTION_OFS, 8'hff);
      wb(1'b1, `GPAB_HIGH_ADDR_PORT_DATA_OFS, 8'h3c);
      rdchk("mode status", `GPAB_MODE_STATUS_OFS, {5'h00, m[0], m});
      rdchk("high pins", `GPAB_HIGH_ADDR_PORT_DATA_OFS, m[0] ? 8'ha7 : 8'h3c);
    end
  endtask : t_modes
  task automatic t_lcd_and_map;
    lcd_en <= 4'hf;
    wb(1'b1, `GPAB_MODE_STATUS_OFS, 8'h00);
    rdchk("lcd pins", `GPAB_HIGH_ADDR_PORT_DATA_OFS, 8'h07);
    rdchk("ro status", `GPAB_MODE_STATUS_OFS, 8'h07);
    rdchk("unmapped", 8'h20, 8'h00);
    sel_i <= 4'he;
    wb(1'b1, `GPAB_HIGH_ADDR_PORT_DIRECTION_OFS, 8'h00);
    sel_i <= 4'hf;
    rdchk("sel ignored", `GPAB_HIGH_ADDR_PORT_DIRECTION_OFS, 8'hff);
  endtask : t_lcd_and_map
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    do_reset(gpab_pkg::GPAB_MODE_SINGLE_CHIP);
    t_reset_state();
    t_timer_port();
    t_pullup();
    t_modes();
    t_lcd_and_map();
    test_done();
  end
endmodule : tb_gpab_ports
